/* File: core/vec_map_regs.svh */
// Constants for the reset and interrupt vector map block
// Functional notes
// R1: POR, LOW_VOLTAGE_RESET, pin, illegal address reset use FFFE
// R2: Clock monitor reset FFFC, gated by enables
// R3: Watchdog reset FFFA, gated by rate select
// R4: Fixed priority, higher offset wins ties; code ranks maskables by programmed level first
// R5: Vector is base plus fixed offset
// R6: Each maskable source has enable and level
// R7: Accumulator overflow DC, edge DA, wait only
// R8: Periodic wake 7E wakes stop and wait
// R9: High temperature 7C wakes wait only
// R10: Periodic timers 7A to 74, wait only
// R11: System call 12, spurious 10, unmasked
// R12: All requests go to main CPU only
// R13: Other sources follow the vector table
// R14: CPU fetches vector honouring I and X masks
// R15: Reset, pins, stop-capable sources end stop
`ifndef VEC_MAP_REGS_SVH
`define VEC_MAP_REGS_SVH

// ----------------------------------------------------------------
// Register offsets (word index on the register port)
// ----------------------------------------------------------------
`define REG_VBR        8'h00
`define REG_PLL_CONTROL_REG     8'h01
`define REG_WDRATE     8'h02
`define REG_ACCCTL     8'h03
`define REG_WAKECTL    8'h04
`define REG_TEMPCTL    8'h05
`define REG_PERIODIC_TIMER_IRQ_EN_REG    8'h06
`define REG_TIMINTE    8'h07
`define REG_INT_STAT   8'h08
`define REG_INT_MASK   8'h09
`define REG_STATE      8'h0A
`define REG_VEC_ADDR   8'h0B
`define REG_CFG_BASE   8'h20
`define REG_CFG_LAST   8'h31

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define VBR_RESET      8'hFF
`define PLL_CME_BIT    1
`define PLL_SELF_CLOCK_MODE_ENABLE_BIT   0
`define PLL_CONTROL_REG_RESET   2'h3
`define CFG_EN_BIT     7
`define CFG_RESET      8'h81
`define NUM_SRC        18
`define STOP_WAKE_MASK 18'h0_1001

// ----------------------------------------------------------------
// Fixed reset vectors and vector offsets
// ----------------------------------------------------------------
`define VEC_RST_MAIN   16'hFFFE
`define VEC_RST_CLKMON 16'hFFFC
`define VEC_RST_WDOG   16'hFFFA
`define OFS_TRAP       8'hF8
`define OFS_SWI        8'hF6
`define OFS_XPIN       8'hF4
`define OFS_IRQPIN     8'hF2
`define OFS_TIM_CH0    8'hEE
`define OFS_TIM_OVF    8'hDE
`define OFS_ACC_OVF    8'hDC
`define OFS_ACC_EDGE   8'hDA
`define OFS_WAKE       8'h7E
`define OFS_TEMP       8'h7C
`define OFS_PIT_CH0    8'h7A
`define OFS_SYS        8'h12
`define OFS_SPUR       8'h10

`endif

/* File: core/vec_map_pkg.sv */
// Types shared by the vector map block
package vec_map_pkg;
  // Offer handshake with the CPU
  typedef enum logic [1:0] {
    st_idle  = 2'b00,
    st_offer = 2'b01,
    st_gap   = 2'b10
  } offer_state_t;
  typedef logic [2:0]  level_t;     // Service priority level
  typedef logic [15:0] reg_data_t;  // Register port data
  typedef logic [7:0]  reg_addr_t;  // Register port address
endpackage : vec_map_pkg

/* File: core/irq_slot.sv */
// One maskable source: its config register and qualified request
`include "vec_map_regs.svh"
module irq_slot (
  input  wire logic                core_clk,
  input  wire logic                rst,
  input  wire logic                cfg_wr,    // Write strobe for this config
  input  wire logic [7:0]          wdata,     // Config write data
  input  wire logic                req,       // Raw peripheral request
  input  wire logic                local_en,  // Peripheral local enable
  input  wire logic                i_mask,    // CPU I bit
  output      logic [7:0]          cfg_q,     // Config readback
  output      vec_map_pkg::level_t level,     // Programmed level
  output      logic                active     // Qualified, unmasked request
);
  import vec_map_pkg::*;

  // ----------------------------------------------------------------
  // Config register: enable and level
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_q <= `CFG_RESET;
    end else if (cfg_wr) begin
      cfg_q <= {wdata[7], 4'h0, wdata[2:0]};
    end
  end

  // Level zero parks the source, same as clearing the enable
  assign level  = cfg_q[2:0];
  assign active = req & local_en & cfg_q[`CFG_EN_BIT] & (level != 3'h0) & ~i_mask; // R6
endmodule : irq_slot

/* File: core/reset_and_irq_vector_map.sv */
// Reset and interrupt vector map with CPU offer handshake
//
// The strobed register port and the placing of the registers are this design's own decisions.
`include "vec_map_regs.svh"
module reset_and_irq_vector_map (
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  // Register port
  input  wire vec_map_pkg::reg_addr_t reg_addr,
  input  wire vec_map_pkg::reg_data_t reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output      vec_map_pkg::reg_data_t reg_rdata,
  // Reset causes from the reset generator, one-cycle pulses
  input  wire logic                   power_on_reset,
  input  wire logic                   low_voltage_reset,
  input  wire logic                   pin_reset,
  input  wire logic                   illegal_addr_reset,
  input  wire logic                   clock_monitor_fail,
  input  wire logic                   watchdog_timer_timeout,
  // CPU exception pulses
  input  wire logic                   unimpl_trap,
  input  wire logic                   software_trap_instr,
  input  wire logic                   system_call_exception,
  input  wire logic                   spurious_event,
  // Asynchronous pins, active low
  input  wire logic                   nonmaskable_pin_request_n,
  input  wire logic                   irq_pin_n,
  // Peripheral request levels
  input  wire logic [7:0]             tim_ch_req,
  input  wire logic                   tim_ovf_req,
  input  wire logic                   acc_ovf_req,
  input  wire logic                   acc_edge_req,
  input  wire logic                   periodic_wake_req,
  input  wire logic                   high_temp_event,
  input  wire logic [3:0]             pit_req,
  // CPU side
  input  wire logic                   cpu_i_mask,
  input  wire logic                   cpu_x_mask,
  input  wire logic                   cpu_stop,
  input  wire logic                   cpu_wait,
  input  wire logic                   vec_ack,
  output      logic                   vec_req,
  output      logic [15:0]            vec_addr,
  output      logic                   wake,
  output      logic                   irq_out
);
  import vec_map_pkg::*;

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  logic [7:0]   vector_base_reg;       // Upper vector byte
  logic [1:0]   pll_control_reg;       // Clock monitor enables
  logic [2:0]   wd_rate;               // Zero means watchdog off
  logic [1:0]   accumulator_control_reg;
  logic         regulator_wake_ctrl_reg;
  logic         regulator_temp_ctrl_reg;
  logic [3:0]   periodic_timer_irq_en_reg;
  logic [8:0]   tim_irq_en_reg;        // Channels 0..7, overflow at 8
  logic [3:0]   int_stat;              // Sticky events
  logic [3:0]   int_mask;              // Event mask
  offer_state_t state;
  logic [6:0]   pend;                  // Latched sources
  logic [6:0]   served;                // Latched sources in the offer
  logic [1:0]   xpin_sync;             // Nonmaskable pin synchroniser
  logic [1:0]   irqpin_sync;           // Maskable pin synchroniser
  logic         wake_d;                // Wake, previous cycle

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  wire clock_monitor_enable   = pll_control_reg[`PLL_CME_BIT];
  wire self_clock_mode_enable = pll_control_reg[`PLL_SELF_CLOCK_MODE_ENABLE_BIT];
  wire wr_vbr   = reg_wr & (reg_addr == `REG_VBR);
  wire wr_pll   = reg_wr & (reg_addr == `REG_PLL_CONTROL_REG);
  wire wr_wd    = reg_wr & (reg_addr == `REG_WDRATE);
  wire wr_acc   = reg_wr & (reg_addr == `REG_ACCCTL);
  wire wr_wake  = reg_wr & (reg_addr == `REG_WAKECTL);
  wire wr_temp  = reg_wr & (reg_addr == `REG_TEMPCTL);
  wire wr_pit   = reg_wr & (reg_addr == `REG_PERIODIC_TIMER_IRQ_EN_REG);
  wire wr_tim   = reg_wr & (reg_addr == `REG_TIMINTE);
  wire wr_stat  = reg_wr & (reg_addr == `REG_INT_STAT);
  wire wr_mask  = reg_wr & (reg_addr == `REG_INT_MASK);
  wire cfg_hit  = (reg_addr >= `REG_CFG_BASE) & (reg_addr <= `REG_CFG_LAST);
  wire [4:0] cfg_idx = 5'(reg_addr - `REG_CFG_BASE);

  // ----------------------------------------------------------------
  // Pin synchronisers, two flops each
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      xpin_sync   <= 2'b00;
      irqpin_sync <= 2'b00;
    end else begin
      xpin_sync   <= {xpin_sync[0], ~nonmaskable_pin_request_n};
      irqpin_sync <= {irqpin_sync[0], ~irq_pin_n};
    end
  end
  wire xpin_req   = xpin_sync[1];
  wire irqpin_req = irqpin_sync[1];

  // ----------------------------------------------------------------
  // Maskable sources, index order follows falling vector offset
  // ----------------------------------------------------------------
  wire [17:0] src_req = {pit_req[3], pit_req[2], pit_req[1], pit_req[0],
                         high_temp_event, periodic_wake_req, acc_edge_req, acc_ovf_req,
                         tim_ovf_req, tim_ch_req[7], tim_ch_req[6], tim_ch_req[5],
                         tim_ch_req[4], tim_ch_req[3], tim_ch_req[2], tim_ch_req[1],
                         tim_ch_req[0], irqpin_req}; // R13
  // Pin source has its enable in its own config register
  wire [17:0] src_en  = {periodic_timer_irq_en_reg[3], periodic_timer_irq_en_reg[2],
                         periodic_timer_irq_en_reg[1], periodic_timer_irq_en_reg[0], // R10
                         regulator_temp_ctrl_reg, regulator_wake_ctrl_reg,           // R8
                         accumulator_control_reg[0], accumulator_control_reg[1],     // R7
                         tim_irq_en_reg, 1'b1};
  logic [17:0]      src_act;
  level_t           src_lvl [`NUM_SRC];
  logic [7:0]       src_cfg [`NUM_SRC];
  logic [7:0]       src_ofs [`NUM_SRC];

  // Offsets: pin F2, timer channels EE..E0, then the fixed ones
  always_comb begin
    for (int i = 0; i < `NUM_SRC; i++) begin
      src_ofs[i] = 8'h00;
    end
    src_ofs[0]  = `OFS_IRQPIN;
    for (int i = 1; i <= 8; i++) begin
      src_ofs[i] = 8'(`OFS_TIM_CH0 - 2 * (i - 1));
    end
    src_ofs[9]  = `OFS_TIM_OVF;
    src_ofs[10] = `OFS_ACC_OVF;  // R7
    src_ofs[11] = `OFS_ACC_EDGE; // R7
    src_ofs[12] = `OFS_WAKE;     // R8
    src_ofs[13] = `OFS_TEMP;     // R9
    for (int i = 14; i < `NUM_SRC; i++) begin
      src_ofs[i] = 8'(`OFS_PIT_CH0 - 2 * (i - 14)); // R10
    end
  end

  for (genvar g = 0; g < `NUM_SRC; g++) begin : g_slot
    irq_slot u_slot (
      .core_clk (core_clk),
      .rst      (rst),
      .cfg_wr   (reg_wr & cfg_hit & (cfg_idx == 5'(g))),
      .wdata    (reg_wdata[7:0]),
      .req      (src_req[g]),
      .local_en (src_en[g]),
      .i_mask   (cpu_i_mask), // R14
      .cfg_q    (src_cfg[g]),
      .level    (src_lvl[g]),
      .active   (src_act[g])
    );
  end

  // Highest level wins; a tie keeps the earlier, higher offset
  logic       m_valid;
  logic [4:0] m_idx;
  level_t     m_lvl;
  always_comb begin
    m_valid = 1'b0;
    m_idx   = 5'd0;
    m_lvl   = 3'd0;
    for (int i = 0; i < `NUM_SRC; i++) begin
      if (src_act[i] && (!m_valid || src_lvl[i] > m_lvl)) begin // R4
        m_valid = 1'b1;
        m_idx   = 5'(i);
        m_lvl   = src_lvl[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Winner selection across all classes
  // ----------------------------------------------------------------
  // Resets first, then trap, swi, pin, maskables, system call, spurious
  wire [4:0] hi_pend  = pend[4:0];
  wire [4:0] hi_sel   = hi_pend & 5'(~hi_pend + 5'd1);
  wire       hi_any   = |hi_pend;
  wire       xpin_win = ~hi_any & xpin_req & ~cpu_x_mask; // R14
  wire       mask_win = ~hi_any & ~xpin_win & m_valid;
  wire       lo_ok    = ~hi_any & ~xpin_win & ~m_valid;
  wire [1:0] lo_sel   = lo_ok ? (pend[5] ? 2'b01 : {pend[6], 1'b0}) : 2'b00;
  wire [6:0] sel_lat  = {lo_sel, hi_sel};
  wire       win_valid = hi_any | xpin_win | mask_win | (|lo_sel);
  // Resets are fixed; every other vector rides on the base register
  wire [15:0] win_addr =
    hi_sel[0] ? `VEC_RST_MAIN :                           // R1
    hi_sel[1] ? `VEC_RST_CLKMON :                         // R2
    hi_sel[2] ? `VEC_RST_WDOG :                           // R3
    hi_sel[3] ? {vector_base_reg, `OFS_TRAP} :            // R13
    hi_sel[4] ? {vector_base_reg, `OFS_SWI} :             // R13
    xpin_win  ? {vector_base_reg, `OFS_XPIN} :            // R13
    mask_win  ? {vector_base_reg, src_ofs[m_idx]} :       // R5
    lo_sel[0] ? {vector_base_reg, `OFS_SYS} :             // R11
                {vector_base_reg, `OFS_SPUR};             // R11

  // ----------------------------------------------------------------
  // Latched pending sources; a new event beats the ack clear
  // ----------------------------------------------------------------
  wire       ack_take = (state == st_offer) & vec_ack;
  wire       cm_block = clock_monitor_fail & self_clock_mode_enable;
  wire [6:0] pend_set = {spurious_event, system_call_exception,
                         software_trap_instr, unimpl_trap,
                         watchdog_timer_timeout & (wd_rate != 3'd0),                    // R3
                         clock_monitor_fail & clock_monitor_enable & ~self_clock_mode_enable, // R2
                         power_on_reset | low_voltage_reset | pin_reset | illegal_addr_reset}; // R1
  wire [6:0] next_pend = (pend & ~(ack_take ? served : 7'h00)) | pend_set;

  // Offer FSM: latch a winner, hold it until the CPU acks, one idle gap
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state    <= st_idle;
      vec_req  <= 1'b0;
      vec_addr <= 16'h0000;
      served   <= 7'h00;
      pend     <= 7'h00;
    end else begin
      pend <= next_pend;
      unique case (state)
        st_idle: begin
          if (win_valid) begin
            state    <= st_offer;
            vec_req  <= 1'b1; // R12
            vec_addr <= win_addr;
            served   <= sel_lat;
          end
        end
        st_offer: begin
          if (vec_ack) begin
            state   <= st_gap;
            vec_req <= 1'b0;
          end
        end
        st_gap: begin
          state <= st_idle;
        end
        default: begin
          state <= st_idle;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Wake from stop and wait
  // ----------------------------------------------------------------
  wire stop_wake = (|pend[2:0]) | xpin_req | (|(src_act & `STOP_WAKE_MASK)); // R15
  wire wait_wake = (|pend[2:0]) | xpin_win | (|src_act);
  wire next_wake = (cpu_stop & stop_wake) | (cpu_wait & wait_wake);

  // ----------------------------------------------------------------
  // Registers, status and interrupt output
  // ----------------------------------------------------------------
  wire [3:0] stat_set = {cm_block, ack_take & served[6], next_wake & ~wake_d,
                         ack_take & (|served[2:0])};
  wire [3:0] stat_clr = wr_stat ? reg_wdata[3:0] : 4'h0;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      vector_base_reg           <= `VBR_RESET;
      pll_control_reg           <= `PLL_CONTROL_REG_RESET;
      wd_rate                   <= 3'd0;
      accumulator_control_reg   <= 2'b00;
      regulator_wake_ctrl_reg   <= 1'b0;
      regulator_temp_ctrl_reg   <= 1'b0;
      periodic_timer_irq_en_reg <= 4'h0;
      tim_irq_en_reg            <= 9'h000;
      int_mask                  <= 4'h0;
    end else begin
      if (wr_vbr)  vector_base_reg           <= reg_wdata[7:0];
      if (wr_pll)  pll_control_reg           <= reg_wdata[1:0];
      if (wr_wd)   wd_rate                   <= reg_wdata[2:0];
      if (wr_acc)  accumulator_control_reg   <= reg_wdata[1:0];
      if (wr_wake) regulator_wake_ctrl_reg   <= reg_wdata[0];
      if (wr_temp) regulator_temp_ctrl_reg   <= reg_wdata[0];
      if (wr_pit)  periodic_timer_irq_en_reg <= reg_wdata[3:0];
      if (wr_tim)  tim_irq_en_reg            <= reg_wdata[8:0];
      if (wr_mask) int_mask                  <= reg_wdata[3:0];
    end
  end

  // Set wins over the write-one clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      int_stat <= 4'h0;
      wake_d   <= 1'b0;
      wake     <= 1'b0;
      irq_out  <= 1'b0;
    end else begin
      int_stat <= (int_stat & ~stat_clr) | stat_set;
      wake_d   <= next_wake;
      wake     <= next_wake;
      irq_out  <= |(((int_stat & ~stat_clr) | stat_set) & int_mask);
    end
  end

  // Read mux; unmapped offsets read zero
  wire [15:0] rd_mux =
    (reg_addr == `REG_VBR)      ? {8'h00, vector_base_reg} :
    (reg_addr == `REG_PLL_CONTROL_REG)   ? {14'h0000, pll_control_reg} :
    (reg_addr == `REG_WDRATE)   ? {13'h0000, wd_rate} :
    (reg_addr == `REG_ACCCTL)   ? {14'h0000, accumulator_control_reg} :
    (reg_addr == `REG_WAKECTL)  ? {15'h0000, regulator_wake_ctrl_reg} :
    (reg_addr == `REG_TEMPCTL)  ? {15'h0000, regulator_temp_ctrl_reg} :
    (reg_addr == `REG_PERIODIC_TIMER_IRQ_EN_REG)  ? {12'h000, periodic_timer_irq_en_reg} :
    (reg_addr == `REG_TIMINTE)  ? {7'h00, tim_irq_en_reg} :
    (reg_addr == `REG_INT_STAT) ? {12'h000, int_stat} :
    (reg_addr == `REG_INT_MASK) ? {12'h000, int_mask} :
    (reg_addr == `REG_STATE)    ? {5'h00, pend, wake, vec_req, state} :
    (reg_addr == `REG_VEC_ADDR) ? vec_addr :
    cfg_hit                     ? {8'h00, src_cfg[cfg_idx]} : 16'h0000;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  main_reset_vec_a: assert property ((state == st_idle) && pend[0] |=> vec_req && vec_addr == 16'hFFFE) // R1
    else $error("Main reset not offered at FFFE");
  clkmon_gate_a: assert property ($rose(pend[1]) |-> $past(clock_monitor_enable && !self_clock_mode_enable)) // R2
    else $error("Clock monitor reset raised while not permitted");
  wdog_gate_a: assert property ($rose(pend[2]) |-> $past(wd_rate != 3'd0)) // R3
    else $error("Watchdog reset raised while watchdog off");
  offer_hold_a: assert property ((state == st_offer) && !vec_ack |=> $stable(vec_addr) && vec_req) // R5
    else $error("Offered vector changed before ack");
  mask_base_a: assert property ((state == st_idle) && mask_win |=> vec_addr[15:8] == $past(vector_base_reg)) // R5
    else $error("Maskable vector not on the base register");
  imask_block_a: assert property (cpu_i_mask |-> !mask_win) // R6
    else $error("Maskable source won under the I mask");
  sys_vec_a: assert property ((state == st_idle) && lo_sel[0] |=> vec_addr == {$past(vector_base_reg), 8'h12}) // R11
    else $error("System call vector wrong");
  ack_gap_a: assert property (ack_take |=> !vec_req ##1 (state == st_idle)) // R12
    else $error("Offer did not close after ack");
  stop_wake_a: assert property (cpu_stop && src_act[12] |=> wake) // R8
    else $error("Periodic wake did not end stop");
  temp_stop_a: assert property (cpu_stop && !cpu_wait && (src_act == 18'h0_2000) && !xpin_req && !(|pend[2:0]) |=> !wake) // R9
    else $error("High temperature ended stop");

  offer_taken_c: cover property (vec_req ##[1:4] vec_ack);
  reset_served_c: cover property (ack_take && served[0]);
  tie_break_c: cover property (mask_win && src_act[14] && src_act[17]);
  stop_exit_c: cover property (cpu_stop ##1 wake);
endmodule : reset_and_irq_vector_map

/* File: sim/cpu_model.sv */
// CPU side model that accepts offered vectors
module cpu_model (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        vec_req,
  input  wire logic [15:0] vec_addr,
  input  wire logic [1:0]  delay,     // Cycles of hesitation
  output      logic        vec_ack,
  output      logic [15:0] last_addr, // Address taken
  output      int          n_acks     // Vectors accepted
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt; // Hesitation counter
  // ---------------------------------------------
  // Accept one offer, then wait for the drop
  // ---------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      vec_ack <= 1'b0;
      n_acks <= 0;
      cnt <= 2'd0;
      last_addr <= 16'h0000;
    end else if (vec_ack) begin // Ack lasts one cycle only
      vec_ack <= 1'b0;
      n_acks <= n_acks + 1;
      cnt <= 2'd0;
    end else if (vec_req && cnt == delay) begin // Fetch at the offered address
      vec_ack <= 1'b1;
      last_addr <= vec_addr;
    end else if (vec_req) begin
      cnt <= cnt + 2'd1;
    end
  end
endmodule : cpu_model

/* File: sim/tb_reset_and_irq_vector_map.sv */
// Bench for the reset and interrupt vector map
module tb_reset_and_irq_vector_map;
  import vec_map_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0;
  reg_addr_t reg_addr = '0;
  reg_data_t reg_wdata = '0, reg_rdata;
  logic [5:0] rsts = '0; // Por, lvr, pin, illegal, clkmon, wdog
  logic [3:0] exc = '0;  // Trap, swi, sys, spurious
  logic xpin_n = 1, irqp_n = 1, i_m = 0, stp = 0, xm = 0, wt = 0;
  logic [16:0] lv = '0;  // Peripheral levels in table order
  logic [1:0] slow = 0;
  logic vec_ack, vec_req, wake, irq_out;
  logic [15:0] vec_addr, last_addr;
  int n_fail = 0, samples_checked = 0, n_acks, i;
  always #4 core_clk = ~core_clk;
  reset_and_irq_vector_map dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .power_on_reset(rsts[0]),
    .low_voltage_reset(rsts[1]), .pin_reset(rsts[2]), .illegal_addr_reset(rsts[3]),
    .clock_monitor_fail(rsts[4]), .watchdog_timer_timeout(rsts[5]), .unimpl_trap(exc[0]),
    .software_trap_instr(exc[1]), .system_call_exception(exc[2]), .spurious_event(exc[3]),
    .nonmaskable_pin_request_n(xpin_n), .irq_pin_n(irqp_n), .tim_ch_req(lv[7:0]), .tim_ovf_req(lv[8]),
    .acc_ovf_req(lv[9]), .acc_edge_req(lv[10]), .periodic_wake_req(lv[11]), .high_temp_event(lv[12]),
    .pit_req(lv[16:13]), .cpu_i_mask(i_m), .cpu_x_mask(xm), .cpu_stop(stp), .cpu_wait(wt),
    .vec_ack(vec_ack), .vec_req(vec_req), .vec_addr(vec_addr), .wake(wake), .irq_out(irq_out));
  cpu_model cpu (.core_clk(core_clk), .rst(rst), .vec_req(vec_req), .vec_addr(vec_addr), .delay(slow),
    .vec_ack(vec_ack), .last_addr(last_addr), .n_acks(n_acks));
  // ---------------------------------------------
  // Shared tasks
  // ---------------------------------------------
  task automatic give_verdict;
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input reg_addr_t a, input reg_data_t d);
    @(posedge core_clk) begin reg_wr <= 1; reg_addr <= a; reg_wdata <= d; end
    @(posedge core_clk) reg_wr <= 0;
  endtask : wr
  // Data stand only in the cycle after the strobe
  task automatic rd(input reg_addr_t a, input reg_data_t e, input string nm);
    @(posedge core_clk) begin reg_rd <= 1; reg_addr <= a; end
    @(posedge core_clk) reg_rd <= 0;
    #1 chk(nm, reg_rdata, e);
  endtask : rd
  task automatic pulse(input logic [5:0] r, input logic [3:0] e);
    @(posedge core_clk) begin rsts <= r; exc <= e; end
    @(posedge core_clk) begin rsts <= 0; exc <= 0; end
  endtask : pulse
  // Bounded wait for the next accepted vector
  task automatic offer(input logic [15:0] e, input string nm);
    int k0 = n_acks;
    for (int k = 0; k < 60 && n_acks == k0; k++) @(posedge core_clk) #1;
    if (n_acks == k0) begin
      n_fail++;
      give_verdict();
    end
    chk(nm, last_addr, e);
  endtask : offer
  task automatic none(input string nm);
    int k0 = n_acks;
    repeat (12) @(posedge core_clk);
    chk(nm, 16'(n_acks - k0), 16'h0000);
  endtask : none
  // Offsets of the maskable peripheral table
  function automatic logic [7:0] ofs(input int k);
    if (k < 8) return 8'hEE - 8'(2 * k);
    if (k < 11) return 8'hDE - 8'(2 * (k - 8));
    if (k < 13) return 8'h7E - 8'(2 * (k - 11));
    return 8'h7A - 8'(2 * (k - 13));
  endfunction : ofs
  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 0;
    rd(8'h00, 16'h00FF, "vbr");
    rd(8'h01, 16'h0003, "pll_control_reg");
    rd(8'h20, 16'h0081, "cfg");
    rd(8'h40, 16'h0000, "unmapped");
    $display("test reset values done");
    i_m <= 1; // Resets ignore the mask
    for (i = 0; i < 4; i++) begin
      pulse(6'(1 << i), 4'h0);
      offer(16'hFFFE, "reset vector");
    end
    i_m <= 0;
    rd(8'h08, 16'h0001, "status");
    wr(8'h09, 16'h0001);
    @(posedge core_clk) #1 chk("irq on", irq_out, 1);
    wr(8'h08, 16'h0001);
    @(posedge core_clk) #1 chk("irq off", irq_out, 0);
    $display("test resets done");
    pulse(6'h10, 4'h0);
    none("clkmon scm");
    rd(8'h08, 16'h0008, "scm status");
    wr(8'h01, 16'h0002);
    pulse(6'h10, 4'h0);
    offer(16'hFFFC, "clkmon");
    pulse(6'h20, 4'h0);
    none("wdog off");
    wr(8'h02, 16'h0001);
    pulse(6'h20, 4'h0);
    offer(16'hFFFA, "wdog");
    $display("test reset gating done");
    wr(8'h00, 16'h0012);
    slow <= 3;
    pulse(6'h00, 4'hF);
    offer(16'h12F8, "trap");
    offer(16'h12F6, "swi");
    offer(16'h1212, "sys");
    offer(16'h1210, "spurious");
    slow <= 0;
    $display("test exceptions done");
    wr(8'h03, 16'h0003);
    wr(8'h04, 16'h0001);
    wr(8'h05, 16'h0001);
    wr(8'h06, 16'h000F);
    wr(8'h07, 16'h01FF);
    for (i = 0; i < 17; i++) begin
      @(posedge core_clk) lv <= 17'(1 << i);
      offer({8'h12, ofs(i)}, "maskable");
      @(posedge core_clk) lv <= '0;
      repeat (10) @(posedge core_clk);
    end
    // One-cycle pin pulses: a pin still low after the gap would be offered twice
    @(posedge core_clk) irqp_n <= 0;
    @(posedge core_clk) irqp_n <= 1;
    offer(16'h12F2, "irq pin");
    @(posedge core_clk) begin xm <= 1; xpin_n <= 0; end
    @(posedge core_clk) xpin_n <= 1;
    none("x mask");
    @(posedge core_clk) begin xm <= 0; xpin_n <= 0; end
    @(posedge core_clk) xpin_n <= 1;
    offer(16'h12F4, "xpin");
    repeat (12) @(posedge core_clk);
    wr(8'h28, 16'h0087);
    @(posedge core_clk) lv <= 17'h0_0181;
    offer(16'h12E0, "level");
    @(posedge core_clk) lv <= 17'h0_0101; // Drop the served level before the gap ends
    offer(16'h12EE, "tie");
    @(posedge core_clk) begin lv <= '0; i_m <= 1; end
    repeat (12) @(posedge core_clk);
    @(posedge core_clk) lv <= 17'h0_0001;
    none("i mask");
    @(posedge core_clk) begin lv <= '0; i_m <= 0; end
    $display("test maskable done");
    @(posedge core_clk) begin stp <= 1; lv <= 17'h0_0200; end
    repeat (3) @(posedge core_clk);
    #1 chk("stop acc", wake, 0);
    @(posedge core_clk) lv <= 17'h0_1000;
    repeat (3) @(posedge core_clk);
    #1 chk("stop temp", wake, 0);
    @(posedge core_clk) begin stp <= 0; wt <= 1; end
    repeat (3) @(posedge core_clk);
    #1 chk("wait temp", wake, 1);
    @(posedge core_clk) begin wt <= 0; stp <= 1; lv <= 17'h0_0800; end
    repeat (3) @(posedge core_clk);
    #1 chk("stop wake", wake, 1);
    @(posedge core_clk) begin lv <= '0; stp <= 0; end
    repeat (12) @(posedge core_clk);
    $display("test wake done");
    give_verdict();
  end
endmodule : tb_reset_and_irq_vector_map
